// File: pkg/ibs_pkg.sv
// Package for the instrument bus service request port.
// Assumes one 100 MHz clock and an APB register bus.
package ibs_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_EVENT   = 8'h08;
    localparam logic [7:0] REG_RXDATA  = 8'h0c;
    localparam logic [7:0] REG_TXDATA  = 8'h10;
    localparam logic [7:0] REG_CARDID  = 8'h14;
    localparam logic [7:0] REG_ADDR    = 8'h18;

    // Card identification, value arbitrary
    localparam logic [31:0] CARD_ID    = 32'h0000_1b5a;

    // Control bits
    localparam int CTRL_BUSY    = 0;
    localparam int CTRL_ERROR   = 1;
    localparam int CTRL_TEST    = 2;
    localparam int CTRL_INITOK  = 3;

    // Event register bits (write one to pulse)
    localparam int EV_MEAS      = 0;
    localparam int EV_BADCODE   = 1;
    localparam int EV_CLRERR    = 2;

    // Status byte positions, bit n of the bus is index n-1
    localparam int SB_RQS       = 6;
    localparam int SB_ERR       = 5;
    localparam int SB_BUSY      = 4;

    localparam int ADDR_W       = 5;
    localparam int CHAR_W       = 7;
    localparam int FIFO_DEPTH   = 16;

    // Bus command bytes (logic-true form)
    localparam logic [7:0] CMD_SPE  = 8'h18;
    localparam logic [7:0] CMD_SPD  = 8'h19;
    localparam logic [7:0] CMD_UNT  = 8'h5f;
    localparam logic [7:0] CMD_UNL  = 8'h3f;
    localparam logic [7:0] TAG_LSN  = 8'h20;
    localparam logic [7:0] TAG_TLK  = 8'h40;

    typedef struct packed {
        logic       attn;
        logic       dataValid;
        logic       ifClear;
        logic [7:0] data;
    } ibs_bus_in_t;

    typedef struct packed {
        logic       srq;
        logic       dataValid;
        logic       notReady;
        logic       notAccepted;
        logic [7:0] data;
        logic       dataOe;
    } ibs_bus_out_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_WAITR = 2'b01,
        TX_VALID = 2'b10
    } ibs_tx_t;

    typedef enum logic [1:0] {
        RX_READY = 2'b00,
        RX_ACCEPT = 2'b01,
        RX_WAITD = 2'b10
    } ibs_rx_t;

endpackage

// File: verilog/ibs_port.sv
// Service request port of an instrument bus interface, with FIFO.
// Bus data pins are negative logic, control pins logic-true, all asynchronous; APB runs on ref_clk.
//
// How it works
// - Own bus address comes from five switch inputs, low five bits.
// - Test mode loops transmitted characters back into the receive path.
// - A fixed card identification word is readable over APB.
// - Service request line is driven high when a request is pending.
// - Measurement-finished event raises a service request.
// - Finishing initialisation after reset raises a service request.
// - An unrecognised programming code raises a request and error.
// - In serial poll talker mode the status byte is sent on lines 8..1.
// - Status bit 7 shows a pending service request.
// - Status bit 6 shows an error condition.
// - Status bit 5 shows busy; bits 8 and 4..1 read zero.
// - Characters go one after another, bits in parallel.
// - Characters carry seven-bit code; bit 8 is sent as zero.
// - Data lines are inverted: low level means logic one.
// - Interface clear returns bus logic to idle.
`timescale 1ns/1ps

module ibs_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
    } ibs_fifo_st_t;

    ibs_fifo_st_t           st_r;
    ibs_fifo_st_t           st_nxt;
    logic [WIDTH-1:0]       mem [DEPTH];
    logic                   doWr;
    logic                   doRd;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depthChk
        $error("FIFO depth must be a power of two");
    end

    assign outValid = st_r.wrPtr != st_r.rdPtr;
    assign inReady  = !((st_r.wrPtr[AW] != st_r.rdPtr[AW]) &&
                        (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]));
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[st_r.rdPtr[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (flush) begin
            st_nxt.wrPtr = '0;
            st_nxt.rdPtr = '0;
        end else begin
            if (doWr) begin
                st_nxt.wrPtr = st_r.wrPtr + 1'b1;
            end
            if (doRd) begin
                st_nxt.rdPtr = st_r.rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (doWr && !flush) begin
            mem[st_r.wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule

module ibs_port
    import ibs_pkg::*;
#(
    parameter int FIFO_D = ibs_pkg::FIFO_DEPTH
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [4:0]           addrSwitch,
    input  wire ibs_pkg::ibs_bus_in_t busIn,
    output ibs_pkg::ibs_bus_out_t     busOut
);
    import ibs_pkg::*;

    typedef struct packed {
        ibs_bus_in_t   s1;
        ibs_bus_in_t   s2;
        logic [4:0]    sw1;
        logic [4:0]    sw2;
        logic [4:0]    myAddr;
        logic [3:0]    ctrl;
        logic          srqPend;
        logic          errFlag;
        logic          talker;
        logic          listener;
        logic          spoll;
        logic          spollSent;
        ibs_tx_t       tx;
        ibs_rx_t       rx;
        logic [7:0]    txByte;
        logic          initDone;
        logic [31:0]   rdata;
        logic          slvErr;
    } ibs_st_t;

    ibs_st_t              st_r;
    ibs_st_t              st_nxt;
    logic                 apbWr;
    logic                 apbRd;
    logic                 rxPush;
    logic [CHAR_W-1:0]    rxChar;
    logic                 rxRdy;
    logic                 rxVal;
    logic [CHAR_W-1:0]    rxOut;
    logic                 rxPop;
    logic                 txVal;
    logic [CHAR_W-1:0]    txOut;
    logic                 txPop;
    logic                 txRdy;
    logic                 txPush;
    logic [7:0]           busData;
    logic [7:0]           statusByte;
    logic                 ifc;

    if (FIFO_D < 2) begin : g_fifoChk
        $error("FIFO_D too small");
    end

    // Bits 8 and 4..1 stay zero
    function automatic logic [7:0] mkStatus(logic rqs, logic err, logic busy);
        logic [7:0] b;
        b         = 8'h00;
        b[SB_RQS] = rqs;
        b[SB_ERR] = err;
        b[SB_BUSY] = busy;
        return b;
    endfunction

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    assign apbWr   = psel && penable && pwrite;
    assign apbRd   = psel && !penable && !pwrite;
    assign prdata  = st_r.rdata;
    assign pslverr = st_r.slvErr & psel & penable;

    assign ifc        = st_r.s2.ifClear;
    assign statusByte = mkStatus(st_r.srqPend, st_r.errFlag,
                                 st_r.ctrl[CTRL_BUSY]);
    assign busData    = ~st_r.s2.data;

    // Test loop feeds transmit FIFO back to receive FIFO
    assign rxChar = st_r.ctrl[CTRL_TEST] ? txOut : busData[CHAR_W-1:0];
    assign txPop  = st_r.ctrl[CTRL_TEST] ? (txVal && rxRdy)
                  : (st_r.tx == TX_IDLE && txVal && st_r.talker && !st_r.spoll
                     && !st_r.s2.attn);
    assign rxPush = st_r.ctrl[CTRL_TEST] ? (txVal && rxRdy)
                  : (st_r.rx == RX_READY && st_r.s2.dataValid && !st_r.s2.attn
                     && st_r.listener && rxRdy);
    assign txPush = apbWr && paddr == REG_TXDATA && txRdy;
    assign rxPop  = psel && penable && !pwrite && paddr == REG_RXDATA;

    ibs_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_D)) u_rxFifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .flush    (ifc),
        .inValid  (rxPush),
        .inReady  (rxRdy),
        .inData   (rxChar),
        .outValid (rxVal),
        .outReady (rxPop),
        .outData  (rxOut)
    );

    ibs_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_D)) u_txFifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .flush    (ifc),
        .inValid  (txPush),
        .inReady  (txRdy),
        .inData   (pwdata[CHAR_W-1:0]),
        .outValid (txVal),
        .outReady (txPop),
        .outData  (txOut)
    );

    always_comb begin
        logic [7:0] cmd;
        cmd    = busData;
        st_nxt = st_r;
        st_nxt.s1  = busIn;
        st_nxt.s2  = st_r.s1;
        st_nxt.sw1 = addrSwitch;
        st_nxt.sw2 = st_r.sw1;
        st_nxt.myAddr = st_r.sw2;

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (apbWr) begin
            unique case (paddr)
                REG_CTRL: begin
                    st_nxt.ctrl = pwdata[3:0];
                    if (pwdata[CTRL_INITOK] && !st_r.initDone) begin
                        st_nxt.initDone = 1'b1;
                        st_nxt.srqPend  = 1'b1;
                    end
                end
                REG_EVENT: begin
                    if (pwdata[EV_CLRERR]) begin
                        st_nxt.errFlag = 1'b0;
                    end
                    if (pwdata[EV_MEAS]) begin
                        st_nxt.srqPend = 1'b1;
                    end
                    if (pwdata[EV_BADCODE]) begin
                        st_nxt.srqPend = 1'b1;
                        st_nxt.errFlag = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // Acceptor: commands under attention, data otherwise
        // --------------------------------------------------------
        unique case (st_r.rx)
            RX_READY: begin
                if (st_r.s2.dataValid && (st_r.s2.attn || rxPush)) begin
                    st_nxt.rx = RX_ACCEPT;
                    if (st_r.s2.attn) begin
                        if (cmd == CMD_SPE) begin
                            st_nxt.spoll = 1'b1;
                        end else if (cmd == CMD_SPD) begin
                            st_nxt.spoll = 1'b0;
                        end else if (cmd == CMD_UNT) begin
                            st_nxt.talker = 1'b0;
                        end else if (cmd == CMD_UNL) begin
                            st_nxt.listener = 1'b0;
                        end else if (cmd[6:5] == TAG_TLK[6:5]) begin
                            st_nxt.talker = cmd[4:0] == st_r.myAddr;
                        end else if (cmd[6:5] == TAG_LSN[6:5]
                                     && cmd[4:0] == st_r.myAddr) begin
                            st_nxt.listener = 1'b1;
                        end
                    end
                end
            end
            RX_ACCEPT: begin
                st_nxt.rx = RX_WAITD;
            end
            RX_WAITD: begin
                if (!st_r.s2.dataValid) begin
                    st_nxt.rx = RX_READY;
                end
            end
            default: begin
                st_nxt.rx = RX_READY;
            end
        endcase

        // --------------------------------------------------------
        // Source: one character at a time
        // --------------------------------------------------------
        unique case (st_r.tx)
            TX_IDLE: begin
                if (st_r.talker && st_r.spoll && !st_r.s2.attn && !st_r.spollSent) begin
                    st_nxt.txByte    = statusByte;
                    st_nxt.spollSent = 1'b1;
                    st_nxt.tx        = TX_WAITR;
                end else if (txPop && !st_r.ctrl[CTRL_TEST]) begin
                    st_nxt.txByte = {1'b0, txOut};
                    st_nxt.tx     = TX_WAITR;
                end
            end
            TX_WAITR: begin
                st_nxt.tx = TX_VALID;
            end
            TX_VALID: begin
                st_nxt.tx = TX_IDLE;
                if (st_r.spollSent && st_r.txByte[SB_RQS]) begin
                    st_nxt.srqPend = 1'b0;
                end
            end
            default: begin
                st_nxt.tx = TX_IDLE;
            end
        endcase
        if (!st_r.spoll) begin
            st_nxt.spollSent = 1'b0;
        end

        // Set after clear: new events above win over poll clear
        if (apbWr && ((paddr == REG_EVENT && (pwdata[EV_MEAS] || pwdata[EV_BADCODE]))
                      || (paddr == REG_CTRL && pwdata[CTRL_INITOK] && !st_r.initDone))) begin
            st_nxt.srqPend = 1'b1;
        end

        // --------------------------------------------------------
        // Register reads, taken in setup phase
        // --------------------------------------------------------
        st_nxt.slvErr = 1'b0;
        if (apbRd) begin
            st_nxt.rdata = 32'h0000_0000;
            unique case (paddr)
                REG_CTRL:   st_nxt.rdata = {28'h0000000, st_r.ctrl};
                REG_STATUS: st_nxt.rdata = {16'h0000, 3'h0, st_r.talker, st_r.listener,
                                            st_r.spoll, txRdy, rxVal, statusByte};
                REG_EVENT:  st_nxt.rdata = 32'h0000_0000;
                REG_RXDATA: st_nxt.rdata = {24'h000000, 1'b0, rxOut};
                REG_TXDATA: st_nxt.rdata = 32'h0000_0000;
                REG_CARDID: st_nxt.rdata = CARD_ID;
                REG_ADDR:   st_nxt.rdata = {27'h0000000, st_r.myAddr};
                default:    st_nxt.slvErr = 1'b1;
            endcase
        end

        if (ifc) begin
            st_nxt.talker    = 1'b0;
            st_nxt.listener  = 1'b0;
            st_nxt.spoll     = 1'b0;
            st_nxt.spollSent = 1'b0;
            st_nxt.tx        = TX_IDLE;
            st_nxt.rx        = RX_READY;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.s1 <= '{attn: 1'b0, dataValid: 1'b0, ifClear: 1'b0, data: 8'hff};
            st_r.s2 <= '{attn: 1'b0, dataValid: 1'b0, ifClear: 1'b0, data: 8'hff};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        busOut             = '0;
        busOut.srq         = st_r.srqPend;
        busOut.dataOe      = st_r.tx != TX_IDLE;
        busOut.data        = ~st_r.txByte;
        busOut.dataValid   = st_r.tx == TX_VALID;
        busOut.notReady    = st_r.rx != RX_READY || !rxRdy;
        busOut.notAccepted = st_r.rx == RX_READY;
    end
endmodule

// File: verification/ibs_port_props.sv
// Checker for the service request port, bound to its top module.
// Assumes ibs_pkg is compiled first and one clock domain.
`timescale 1ns/1ps
module ibs_port_props
    import ibs_pkg::*;
#(
    parameter int FIFO_D = ibs_pkg::FIFO_DEPTH
) (
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic [7:0]            paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [4:0]            addrSwitch,
    input wire ibs_pkg::ibs_bus_in_t  busIn,
    input wire ibs_pkg::ibs_bus_out_t busOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic acc;
    logic initSeen_r;
    assign acc = psel && penable;

    // ------------------------------------------------------------
    // Access phases
    // ------------------------------------------------------------
    sequence s_rd(a);
        acc && !pwrite && paddr == a;
    endsequence
    sequence s_wr(a, b);
        acc && pwrite && paddr == a && pwdata[b];
    endsequence

    // Only the first init-done write raises a request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            initSeen_r <= 1'b0;
        end else if (acc && pwrite && paddr == REG_CTRL && pwdata[CTRL_INITOK]) begin
            initSeen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_addr;
        $stable(addrSwitch)[*4] ##0 s_rd(REG_ADDR) |-> prdata[4:0] == addrSwitch;
    endproperty
    property p_cardid;
        s_rd(REG_CARDID) |-> prdata == CARD_ID;
    endproperty
    property p_meas;
        s_wr(REG_EVENT, EV_MEAS) |-> ##[1:4] busOut.srq;
    endproperty
    property p_init;
        !initSeen_r ##0 s_wr(REG_CTRL, CTRL_INITOK) |-> ##[1:4] busOut.srq;
    endproperty
    property p_bad;
        s_wr(REG_EVENT, EV_BADCODE) |-> ##[1:4] busOut.srq;
    endproperty
    property p_bit8;
        busOut.dataOe && busOut.dataValid |-> busOut.data[7];
    endproperty
    property p_ifc;
        busIn.ifClear[*5] |-> !busOut.dataOe;
    endproperty
    property p_clr;
        $fell(busOut.srq) |-> $past(busOut.dataValid) || $past(busOut.dataValid, 2)
            || $past(busOut.dataValid, 3);
    endproperty

    a_addr: assert property (p_addr) else $error("own address read wrong");
    a_cardid: assert property (p_cardid) else $error("card id wrong");
    a_meas: assert property (p_meas) else $error("no request on measure");
    a_init: assert property (p_init) else $error("no request on init");
    a_bad: assert property (p_bad) else $error("no request on bad code");
    a_bit8: assert property (p_bit8) else $error("bit 8 driven as one");
    a_ifc: assert property (p_ifc) else $error("bus not idle on clear");
    a_clr: assert property (p_clr) else $error("request cleared unpolled");
endmodule

bind ibs_port ibs_port_props #(.FIFO_D(FIFO_D)) i_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .addrSwitch(addrSwitch), .busIn(busIn), .busOut(busOut)
);

// File: verification/ibs_ctrl_model.sv
// Bus controller model facing the service request port.
// Assumes negative-logic data and logic-true control lines.
`timescale 1ns/1ps
module ibs_ctrl_model
    import ibs_pkg::*;
(
    input  wire logic                  ref_clk,
    output ibs_pkg::ibs_bus_in_t       busIn,
    input  wire ibs_pkg::ibs_bus_out_t busOut
);
    logic [7:0] talkByte;
    int         talkCnt;

    initial begin
        busIn = '0;
        busIn.data = 8'hff;
        talkCnt = 0;
    end

    // Bytes the port talks, back in logic form
    always @(posedge ref_clk) begin
        if (busOut.dataOe === 1'b1 && busOut.dataValid === 1'b1) begin
            talkByte <= ~busOut.data;
            talkCnt <= talkCnt + 1;
        end
    end

    task automatic setAttn(input logic a);
        @(posedge ref_clk);
        busIn.attn <= a;
    endtask

    task automatic setIfc(input logic c);
        @(posedge ref_clk);
        busIn.ifClear <= c;
    endtask

    // One character with the full three-wire handshake
    task automatic send(input logic a, input logic [7:0] v, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge ref_clk);
        busIn.attn <= a;
        for (n = 0; n < 40 && busOut.notReady !== 1'b0; n++) @(posedge ref_clk);
        if (n == 40) return;
        busIn.data <= ~v;
        busIn.dataValid <= 1'b1;
        @(posedge ref_clk);
        for (n = 0; n < 40 && busOut.notAccepted !== 1'b0; n++) @(posedge ref_clk);
        busIn.dataValid <= 1'b0;
        busIn.data <= 8'hff;
        ok = (n < 40);
        for (n = 0; n < 40 && busOut.notAccepted !== 1'b1; n++) @(posedge ref_clk);
    endtask
endmodule

// File: verification/ibs_port_tb_top.sv
// Testbench top for the service request port.
// Assumes package, port, checker and controller model compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module ibs_port_tb_top;
    import ibs_pkg::*;
    localparam logic [4:0] MY_ADDR = 5'h0b;
    logic                 ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic                 slverr, ok;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [4:0]           addrSwitch;
    ibs_bus_in_t          busIn;
    ibs_bus_out_t         busOut;
    int                   err_count, n_tests, i, cnt;

    ibs_port #(.FIFO_D(FIFO_DEPTH)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addrSwitch(addrSwitch), .busIn(busIn), .busOut(busOut)
    );
    ibs_ctrl_model i_ctrl (.ref_clk(ref_clk), .busIn(busIn), .busOut(busOut));

    always #5 ref_clk = ~ref_clk;

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitSrq(input logic v);
        for (int n = 0; n < 60 && busOut.srq !== v; n++) @(posedge ref_clk);
        `CHK("srq", v, busOut.srq)
    endtask

    // Serial poll: enable, address as talker, take one byte, disable
    task automatic poll(input logic [7:0] exp);
        int c;
        i_ctrl.send(1'b1, CMD_SPE, ok);
        i_ctrl.send(1'b1, TAG_TLK | {3'b000, MY_ADDR}, ok);
        c = i_ctrl.talkCnt;
        i_ctrl.setAttn(1'b0);
        for (int n = 0; n < 60 && i_ctrl.talkCnt == c; n++) @(posedge ref_clk);
        `CHK("status byte", exp, i_ctrl.talkByte)
        i_ctrl.send(1'b1, CMD_SPD, ok);
        i_ctrl.send(1'b1, CMD_UNT, ok);
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        addrSwitch = MY_ADDR;
        err_count = 0;
        n_tests = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        `CHK("srq at reset", 1'b0, busOut.srq)
        apb(1'b0, REG_CARDID, '0);
        `CHK("card id", CARD_ID, rd)
        `CHK("mapped read ok", 1'b0, slverr)
        apb(1'b0, REG_ADDR, '0);
        `CHK("own address", MY_ADDR, rd[4:0])
        apb(1'b0, 8'h1c, '0);
        `CHK("unmapped", 1'b1, slverr)
        apb(1'b1, REG_CTRL, 32'h1 << CTRL_INITOK);
        waitSrq(1'b1);
        poll(8'h40);
        waitSrq(1'b0);
        apb(1'b1, REG_CTRL, (32'h1 << CTRL_INITOK) | (32'h1 << CTRL_BUSY));
        apb(1'b1, REG_EVENT, 32'h1 << EV_MEAS);
        waitSrq(1'b1);
        poll(8'h50);
        apb(1'b1, REG_EVENT, 32'h1 << EV_BADCODE);
        waitSrq(1'b1);
        poll(8'h70);
        apb(1'b1, REG_EVENT, 32'h1 << EV_CLRERR);
        apb(1'b1, REG_CTRL, 32'h1 << CTRL_INITOK);
        apb(1'b0, REG_STATUS, '0);
        `CHK("status idle", 8'h00, rd[7:0])
        // Listener: fill until refused, then drain
        i_ctrl.send(1'b1, TAG_LSN | {3'b000, MY_ADDR}, ok);
        for (i = 0; i <= FIFO_DEPTH; i++) begin
            i_ctrl.send(1'b0, 8'h30 + i[7:0], ok);
            `CHK("char taken", i < FIFO_DEPTH, ok)
        end
        apb(1'b0, REG_STATUS, '0);
        `CHK("listener", 1'b1, rd[11])
        for (i = 0; i < FIFO_DEPTH; i++) begin
            apb(1'b0, REG_RXDATA, '0);
            `CHK("rx char", 7'h30 + i[6:0], rd[6:0])
        end
        apb(1'b0, REG_STATUS, '0);
        `CHK("rx empty", 1'b0, rd[8])
        // Interface clear in mid-traffic
        i_ctrl.send(1'b0, 8'h41, ok);
        apb(1'b1, REG_EVENT, 32'h1 << EV_MEAS);
        i_ctrl.setIfc(1'b1);
        repeat (6) @(posedge ref_clk);
        i_ctrl.setIfc(1'b0);
        apb(1'b0, REG_STATUS, '0);
        `CHK("rx flushed", 1'b0, rd[8])
        `CHK("listener idle", 1'b0, rd[11])
        `CHK("srq kept", 1'b1, busOut.srq)
        // Talker: one data character out, bit 8 sent as zero
        i_ctrl.send(1'b1, TAG_TLK | {3'b000, MY_ADDR}, ok);
        apb(1'b1, REG_TXDATA, 32'h0000_0063);
        cnt = i_ctrl.talkCnt;
        i_ctrl.setAttn(1'b0);
        for (i = 0; i < 60 && i_ctrl.talkCnt == cnt; i++) @(posedge ref_clk);
        `CHK("talk char", 8'h63, i_ctrl.talkByte)
        i_ctrl.send(1'b1, CMD_UNT, ok);
        // Self-test loop
        apb(1'b1, REG_CTRL, (32'h1 << CTRL_INITOK) | (32'h1 << CTRL_TEST));
        apb(1'b1, REG_TXDATA, 32'h5a);
        rd = '0;
        for (i = 0; i < 40 && rd[8] !== 1'b1; i++) apb(1'b0, REG_STATUS, '0);
        apb(1'b0, REG_RXDATA, '0);
        `CHK("loopback", 7'h5a, rd[6:0])
        end_of_test();
    end
endmodule
